// File: rtl/ldc_top.sv
// LED direct control: register, indicator sources, blink and stretch.
// Assumes a 40 MHz clock and single-cycle register strobes, one at a time.
//
// Contract
// [R1] Bits 15:9 read as zero, writes to them are dropped.
// [R2] Bit 8 set: activity shows receive only; clear: transmit or receive.
// [R3] Bits 7:6 pick link blink rate 6, 12, 24 or 48 Hz.
// [R4] Bit 5 set drives speed indicator from bit 2.
// [R5] Bit 4 set drives link indicator from bit 1.
// [R6] Bit 3 set drives activity/collision indicator from bit 0.
// [R7] Reads return stored bits, never indicator pin levels.
// [R8] The register decodes at address 18h.
// [R9] Stretch bypass shows raw status without pulse stretching.
// [R10] Override changes reach outputs within cycles, glitch free.
module ldc_top #(
    parameter int unsigned BLINK_HALF = ldc_pkg::BLINK_HALF_CYC,
    parameter int unsigned STRETCH    = ldc_pkg::STRETCH_CYC
) (
    input  wire logic        clock_i,        // 40 MHz clock
    input  wire logic        rst_n_i,        // Async reset, active low
    input  wire logic [4:0]  addr_i,         // Register address
    input  wire logic [15:0] wdata_i,        // Write data
    input  wire logic        wr_i,           // Write strobe
    input  wire logic        rd_i,           // Read strobe
    output logic      [15:0] rdata_o,        // Read data, cycle after rd_i
    input  wire logic        speed_100_i,    // Link runs at 100 Mb/s
    input  wire logic        link_up_i,      // Link is up
    input  wire logic        blink_en_i,     // Blink link LED on activity
    input  wire logic        rx_active_i,    // Receive activity
    input  wire logic        tx_active_i,    // Transmit activity
    input  wire logic        collision_i,    // Collision seen
    input  wire logic        col_mode_i,     // Shared pin shows collision
    output logic             speed_indicator_out_o,            // Speed LED
    output logic             link_indicator_out_o,             // Link LED
    output logic             activity_collision_indicator_out_o // Act/col LED
);
    logic        rst_s1;
    logic        rst_n;
    logic [15:0] led_direct_control;
    logic [15:0] next_ctrl;
    logic        indicator_stretch_bypass;
    logic        next_bypass;
    logic [15:0] next_rdata;
    logic [ldc_pkg::CNT_W-1:0] blink_cnt;
    logic [ldc_pkg::CNT_W-1:0] next_blink_cnt;
    logic [ldc_pkg::CNT_W-1:0] blink_limit;
    logic        blink_phase;
    logic        next_blink_phase;
    logic        act_raw;
    logic        act_str;
    logic        col_str;
    logic        act_src;
    logic        col_src;
    logic        next_spd;
    logic        next_lnk;
    logic        next_act;

    // Reset release through two flops
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    function automatic logic hit(input logic [4:0] a, input logic [4:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    // Register file
    always_comb begin
        next_ctrl   = led_direct_control;
        next_bypass = indicator_stretch_bypass;
        next_rdata  = 16'h0000;
        if (wr_i && hit(addr_i, ldc_pkg::ADDR_LEDCTRL)) begin   // [R8]
            next_ctrl = wdata_i & ldc_pkg::LEDCTRL_MASK;         // [R1]
        end
        if (wr_i && hit(addr_i, ldc_pkg::ADDR_STRETCH)) begin
            next_bypass = wdata_i[ldc_pkg::BIT_STRETCH_BP];
        end
        if (rd_i && hit(addr_i, ldc_pkg::ADDR_LEDCTRL)) begin
            // Stored bits only; LED pin levels are not visible here
            next_rdata = led_direct_control;                     // [R7] [R1]
        end else if (rd_i && hit(addr_i, ldc_pkg::ADDR_STRETCH)) begin
            next_rdata[ldc_pkg::BIT_STRETCH_BP] = indicator_stretch_bypass;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            led_direct_control       <= ldc_pkg::LEDCTRL_RESET;
            indicator_stretch_bypass <= 1'b0;
            rdata_o                  <= 16'h0000;
        end else begin
            led_direct_control       <= next_ctrl;
            indicator_stretch_bypass <= next_bypass;
            rdata_o                  <= next_rdata;
        end
    end

    // Blink: half period halves per rate code step
    assign blink_limit = ldc_pkg::CNT_W'(BLINK_HALF)
        >> led_direct_control[ldc_pkg::BIT_RATE_LO +: 2];         // [R3]

    always_comb begin
        next_blink_cnt   = blink_cnt + 1'b1;
        next_blink_phase = blink_phase;
        if (blink_cnt + 1'b1 >= blink_limit) begin               // [R3]
            next_blink_cnt   = '0;
            next_blink_phase = ~blink_phase;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
        end else begin
            blink_cnt   <= next_blink_cnt;
            blink_phase <= next_blink_phase;
        end
    end

    // Activity source select
    assign act_raw = led_direct_control[ldc_pkg::BIT_ACT_RX] ? rx_active_i
                   : (rx_active_i | tx_active_i);                // [R2]

    // One stretcher per raw indication: index 0 activity, index 1 collision
    logic [1:0] str_raw;
    logic [1:0] str_out;

    assign str_raw = {collision_i, act_raw};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_stretch
            ldc_stretch #(
                .HOLD_CYC (STRETCH)
            ) u_stretch (
                .clock_i (clock_i),
                .rst_n_i (rst_n),
                .pulse_i (str_raw[g]),
                .level_o (str_out[g])
            );
        end
    endgenerate

    assign act_str = str_out[0];
    assign col_str = str_out[1];

    assign act_src = indicator_stretch_bypass ? act_raw : act_str;       // [R9]
    assign col_src = indicator_stretch_bypass ? collision_i : col_str;   // [R9]

    // Source selection; outputs are flops so a source swap cannot glitch
    always_comb begin
        next_spd = led_direct_control[ldc_pkg::BIT_SPD_OVR]
                 ? led_direct_control[ldc_pkg::BIT_SPD_VAL] : speed_100_i;  // [R4]
        if (led_direct_control[ldc_pkg::BIT_LNK_OVR]) begin
            next_lnk = led_direct_control[ldc_pkg::BIT_LNK_VAL];            // [R5]
        end else if (link_up_i && blink_en_i && act_src) begin
            next_lnk = blink_phase;                                         // [R3]
        end else begin
            next_lnk = link_up_i;
        end
        if (led_direct_control[ldc_pkg::BIT_ACT_OVR]) begin
            next_act = led_direct_control[ldc_pkg::BIT_ACT_VAL];            // [R6]
        end else begin
            next_act = col_mode_i ? col_src : act_src;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            speed_indicator_out_o              <= 1'b0;
            link_indicator_out_o               <= 1'b0;
            activity_collision_indicator_out_o <= 1'b0;
        end else begin
            speed_indicator_out_o              <= next_spd;   // [R10]
            link_indicator_out_o               <= next_lnk;   // [R10]
            activity_collision_indicator_out_o <= next_act;   // [R10]
        end
    end
endmodule : ldc_top

// File: rtl/ldc_pkg.sv
// Constants for the LED direct control block.
// Assumes a 40 MHz core clock and a 5-bit management register address.
package ldc_pkg;
    localparam int unsigned CLK_HZ        = 40000000;
    localparam logic [4:0]  ADDR_LEDCTRL  = 5'h18;
    localparam logic [4:0]  ADDR_STRETCH  = 5'h19;
    localparam logic [15:0] LEDCTRL_RESET = 16'h0000;
    localparam logic [15:0] LEDCTRL_MASK  = 16'h01FF;
    localparam int unsigned BIT_ACT_RX    = 8;
    localparam int unsigned BIT_RATE_LO   = 6;
    localparam int unsigned BIT_SPD_OVR   = 5;
    localparam int unsigned BIT_LNK_OVR   = 4;
    localparam int unsigned BIT_ACT_OVR   = 3;
    localparam int unsigned BIT_SPD_VAL   = 2;
    localparam int unsigned BIT_LNK_VAL   = 1;
    localparam int unsigned BIT_ACT_VAL   = 0;
    localparam int unsigned BIT_STRETCH_BP = 7;
    // Blink rate in Hz for code 0; each code step doubles it
    localparam int unsigned BLINK_BASE_HZ = 6;
    // Half period of the slowest blink, in clock cycles
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_BASE_HZ);
    localparam int unsigned STRETCH_MS     = 50;
    localparam int unsigned STRETCH_CYC    = (CLK_HZ / 1000) * STRETCH_MS;
    localparam int unsigned CNT_W          = 24;
endpackage : ldc_pkg

// File: rtl/ldc_stretch.sv
// Pulse stretcher for one indicator: holds a seen pulse for a set time.
// Assumes an active-low reset already released through the top's synchroniser.
module ldc_stretch #(
    parameter int unsigned HOLD_CYC = 2000000
) (
    input  wire logic clock_i,  // Core clock
    input  wire logic rst_n_i,  // Synchronised reset
    input  wire logic pulse_i,  // Raw status
    output logic      level_o   // Stretched status
);
    logic [ldc_pkg::CNT_W-1:0] cnt;
    logic [ldc_pkg::CNT_W-1:0] next_cnt;

    always_comb begin
        if (pulse_i) begin
            next_cnt = ldc_pkg::CNT_W'(HOLD_CYC);
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign level_o = (cnt != '0);
endmodule : ldc_stretch

// File: testbench/ldc_chk.sv
// Port checker for the LED direct control block.
// Assumes single-cycle strobes; bound from the bench top file.
module ldc_chk (
    input wire logic        clock_i,                           // Clock
    input wire logic        rst_n_i,                           // Reset
    input wire logic [4:0]  addr_i,                            // Address
    input wire logic [15:0] wdata_i,                           // Data in
    input wire logic        wr_i,                              // Write
    input wire logic        rd_i,                              // Read
    input wire logic [15:0] rdata_o,                           // Data out
    input wire logic        speed_indicator_out_o,             // Speed
    input wire logic        link_indicator_out_o,              // Link
    input wire logic        activity_collision_indicator_out_o // Act
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] sh;
    logic [1:0] stab;
    // Stability age lets override checks ignore the two-cycle update path
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh   <= 9'h000;
            stab <= 2'h0;
        end else if (wr_i && addr_i == 5'h18 && wdata_i[8:0] != sh) begin
            sh   <= wdata_i[8:0];
            stab <= 2'h0;
        end else if (stab != 2'h3) begin
            stab <= stab + 2'h1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd18; $past(rd_i) && $past(addr_i) == 5'h18 |-> rdata_o == {7'h00, $past(sh)};
    endproperty
    a_rd18: assert property (p_rd18) else $error("control read wrong");
    property p_rd19;
        $past(rd_i) && $past(addr_i) == 5'h19
            |-> rdata_o[15:8] == 8'h00 && rdata_o[6:0] == 7'h00;
    endproperty
    a_rd19: assert property (p_rd19) else $error("bypass read wrong");
    property p_rdx;
        $past(rd_i) && $past(addr_i) != 5'h18 && $past(addr_i) != 5'h19
            |-> rdata_o == 16'h0000;
    endproperty
    a_rdx: assert property (p_rdx) else $error("unmapped read nonzero");
    property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside slot");
    property p_rsv; rdata_o[15:9] == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
    property p_spd; stab == 2'h3 && sh[5] |-> speed_indicator_out_o == sh[2];
    endproperty
    a_spd: assert property (p_spd) else $error("speed override lost");
    property p_lnk; stab == 2'h3 && sh[4] |-> link_indicator_out_o == sh[1];
    endproperty
    a_lnk: assert property (p_lnk) else $error("link override lost");
    property p_act; stab == 2'h3 && sh[3] |-> activity_collision_indicator_out_o == sh[0];
    endproperty
    a_act: assert property (p_act) else $error("activity override lost");
endmodule : ldc_chk

// File: testbench/ldc_led_board.sv
// Board LED model: a lamp is lit while its drive is high.
// Assumes active-high directly driven indicators.
module ldc_led_board (
    input  wire logic       speed_i, // Speed drive
    input  wire logic       link_i,  // Link drive
    input  wire logic       act_i,   // Act/col drive
    output logic      [2:0] lamps_o  // Lit lamps
);
    timeunit 1ns;
    timeprecision 100ps;
    assign lamps_o = {speed_i, link_i, act_i};
endmodule : ldc_led_board

// File: testbench/tb_led_direct_override_control.sv
// Bench for the LED direct control block with board LED model.
// Assumes short blink and stretch counts set at the instance.
`define CHK(a, b) begin \
    n_checks++; \
    if ((a) !== (b)) begin \
        mismatches++; \
        $display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); \
    end \
end
module tb_led_direct_override_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [4:0]  addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [6:0]  st = 7'h00;
    logic [15:0] rdata_o;
    logic [15:0] d;
    logic        spd, lnk, act;
    logic [2:0]  lamps;
    int          mismatches = 0;
    int          n_checks = 0;
    always #12.5 clock_i = ~clock_i;
    ldc_top #(.BLINK_HALF(16), .STRETCH(8)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .speed_100_i(st[6]), .link_up_i(st[5]), .blink_en_i(st[4]), .rx_active_i(st[3]),
        .tx_active_i(st[2]), .collision_i(st[1]), .col_mode_i(st[0]),
        .speed_indicator_out_o(spd), .link_indicator_out_o(lnk),
        .activity_collision_indicator_out_o(act));
    ldc_led_board u_leds (.speed_i(spd), .link_i(lnk), .act_i(act), .lamps_o(lamps));
    function automatic logic [15:0] exp_rd(input logic [15:0] v);
        return {7'h00, v[8:0]};
    endfunction : exp_rd
    // Speed lamp: forced value when overridden, else the speed status input
    function automatic logic exp_spd(input logic [15:0] v, input logic [6:0] s);
        return v[5] ? v[2] : s[6];
    endfunction : exp_spd
    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask : rd
    // Second half period is measured, the first may be cut by the rate change
    task automatic blink(input int c);
        int n;
        logic p;
        wr(5'h18, {8'h00, 2'(c), 6'h00});
        for (int k = 0; k < 2; k++) begin
            p = lnk;
            n = 0;
            while (lnk === p && n < 40) begin
                @(posedge clock_i);
                #1 n++;
            end
        end
        `CHK(n, 16 >> c)
    endtask : blink
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        report_and_stop();
    end
    initial begin
        void'($urandom(60290));
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rd(5'h18, 16'h0000);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            @(posedge clock_i);
            st <= 7'($urandom);
            wr(5'h18, d);
            rd(5'h18, exp_rd(d));
            repeat (2) @(posedge clock_i);
            #1 `CHK(lamps & d[5:3], d[2:0] & d[5:3])
            `CHK(lamps[2], exp_spd(d, st))
        end
        wr(5'h03, 16'hFFFF);
        rd(5'h03, 16'h0000);
        rd(5'h18, exp_rd(d));
        wr(5'h19, 16'h0080);
        rd(5'h19, 16'h0080);
        wr(5'h18, 16'h0100);
        st <= 7'h04;
        repeat (4) @(posedge clock_i);
        #1 `CHK(act, 1'b0)
        wr(5'h18, 16'h0000);
        repeat (4) @(posedge clock_i);
        #1 `CHK(act, 1'b1)
        @(posedge clock_i);
        st <= 7'h00;
        repeat (3) @(posedge clock_i);
        #1 `CHK(act, 1'b0)
        // Normal sources: speed, link up without blink, collision shown
        @(posedge clock_i);
        st <= 7'h63;
        repeat (2) @(posedge clock_i);
        #1 `CHK(lamps, 3'b111)
        @(posedge clock_i);
        st <= 7'h38;
        for (int c = 0; c < 4; c++) blink(c);
        report_and_stop();
    end
endmodule : tb_led_direct_override_control
bind ldc_top ldc_chk u_chk (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .speed_indicator_out_o(speed_indicator_out_o), .link_indicator_out_o(link_indicator_out_o),
    .activity_collision_indicator_out_o(activity_collision_indicator_out_o));
